// ===== rsc_pkg.sv
package rsc_pkg;
  // clock and start-up timing
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned POR_DELAY_MS = 48;
  localparam int unsigned CLR_DELAY_MS = 16;
  localparam int unsigned POR_DELAY_CYC = POR_DELAY_MS * CLK_KHZ;
  localparam int unsigned CLR_DELAY_CYC = CLR_DELAY_MS * CLK_KHZ;
  localparam int unsigned FAULT_DELAY_CYC = 16;
  localparam int unsigned BO_FILTER_CYC = 8;

  // register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_GUARD = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_LEVEL = 8'h08;

  // pin function codes
  localparam logic [7:0] GUARD_GPIO = 8'h55;
  localparam logic [7:0] GUARD_CLEAR = 8'hAA;
  localparam logic [7:0] GUARD_RESET = GUARD_GPIO;

  // brownout level codes
  localparam logic [7:0] LVL_2V10 = 8'h55;
  localparam logic [7:0] LVL_2V55 = 8'h33;
  localparam logic [7:0] LVL_3V15 = 8'h99;
  localparam logic [7:0] LVL_3V80 = 8'hAA;
  localparam logic [7:0] LEVEL_RESET = LVL_2V10;

  // reset cause flag positions
  localparam int unsigned FLAGS_W = 4;
  localparam int unsigned FLG_WDT = 0;
  localparam int unsigned FLG_LVL = 1;
  localparam int unsigned FLG_BO = 2;
  localparam int unsigned FLG_GUARD = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  typedef enum logic [1:0] {THR_2V10, THR_2V55, THR_3V15, THR_3V80} rsc_thr_t;

  function automatic logic rsc_guard_ok(input logic [7:0] code);
    return (code == GUARD_GPIO) || (code == GUARD_CLEAR);
  endfunction

  function automatic logic rsc_level_ok(input logic [7:0] code);
    return (code == LVL_2V10) || (code == LVL_2V55) || (code == LVL_3V15) ||
           (code == LVL_3V80);
  endfunction

  function automatic rsc_thr_t rsc_level_thr(input logic [7:0] code);
    rsc_thr_t t;
    t = THR_2V10;
    if (code == LVL_2V55) t = THR_2V55;
    if (code == LVL_3V15) t = THR_3V15;
    if (code == LVL_3V80) t = THR_3V80;
    return t;
  endfunction
endpackage

// ===== rsc_top.sv
// Overview of operation
// - power-on reset holds core reset so program counter restarts at zero.
// - after power-on, port data and control registers are preset to all ones.
// - power-on holds internal reset for the 48 ms start-up delay.
// - enabled external clear pin driven low resets the core.
// - after clear pin returns high, wait 16 ms before running.
// - pin code 0x55 selects general I/O, 0xAA selects external clear.
// - any other pin code resets after fault delay and sets guard fault flag.
// - guard fault flag set only by that fault, cleared only by writing zero.
// - every reset except watchdog time-out restores pin code to 0x55.
// - clear-pin selection overrides all other pin sharing controls.
// - upper four bits of the cause flag register read zero.
// - brownout on except during power-down; resets only when low supply outlasts filter time.
// - genuine brownout sets brownout flag; cleared only by writing zero.
// - level codes 0x55, 0x33, 0x99, 0xAA select 2.1, 2.55, 3.15, 3.8 V.
// - invalid level code resets after fault delay and restores level code.
// - genuine low-voltage reset leaves the level code unchanged.
// - level code fault flag set on invalid code; cleared only by writing zero.
// - brownout detector disabled during power-down.
// - external clear reset keeps some registers and resumes after pin high.
// - level code register holds 0x55 after power-on.
// - watchdog control fault sets its flag; cleared only by writing zero.
`timescale 1ns/1ps
module rsc_top #(
  parameter int unsigned POR_CYC = rsc_pkg::POR_DELAY_CYC,
  parameter int unsigned CLR_CYC = rsc_pkg::CLR_DELAY_CYC,
  parameter int unsigned FAULT_CYC = rsc_pkg::FAULT_DELAY_CYC,
  parameter int unsigned BO_FILT_CYC = rsc_pkg::BO_FILTER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_clear_pin,
  input wire logic supply_low,
  input wire logic power_down,
  input wire logic watchdog_timeout,
  input wire logic watchdog_ctrl_fault,
  output logic core_rst_n,
  output logic port_preset,
  output logic pin_clear_sel,
  output logic pin_gpio_sel,
  output logic brownout_en,
  output rsc_pkg::rsc_thr_t brownout_threshold
);
  import rsc_pkg::*;

  localparam int unsigned MAXC = (POR_CYC > CLR_CYC) ? POR_CYC : CLR_CYC;
  localparam int unsigned CW = $clog2(MAXC + 1);
  localparam int unsigned BW = $clog2(BO_FILT_CYC + 1);

  generate
    if (POR_CYC < 1 || CLR_CYC < 1 || FAULT_CYC < 1 || FAULT_CYC > MAXC ||
        BO_FILT_CYC < 1) begin : g_bad
      $error("rsc_top: delay parameters out of range");
    end
  endgenerate

  typedef enum {RS_HOLD, RS_EXT_LOW, RS_FAULT_DLY, RS_RUN} rsc_state_t;

  rsc_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [BW-1:0] bo_cnt_q, bo_cnt_d;
  logic [7:0] guard_q, guard_d;
  logic [7:0] level_q, level_d;
  logic [FLAGS_W-1:0] flags_q, flags_d;
  logic fault_lvl_q, fault_lvl_d;
  logic fault_grd_q, fault_grd_d;
  logic por_q, por_d;
  logic core_rst_n_q;
  logic [31:0] prdata_q;

  // bus decode
  wire hit_guard = (paddr == ADDR_GUARD);
  wire hit_flags = (paddr == ADDR_FLAGS);
  wire hit_level = (paddr == ADDR_LEVEL);
  wire hit_any = hit_guard | hit_flags | hit_level;
  wire access = psel & penable;
  wire wr_ok = access & pwrite & hit_any;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire wr_guard = wr_ok & hit_guard;
  wire wr_flags = wr_ok & hit_flags;
  wire wr_level = wr_ok & hit_level;
  wire [31:0] rd_mux = hit_guard ? {24'h000000, guard_q} :
                       hit_flags ? {28'h0000000, flags_q} :
                       hit_level ? {24'h000000, level_q} : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;
  assign prdata = prdata_q;

  // pin sharing and brownout controls
  assign pin_clear_sel = (guard_q == GUARD_CLEAR);
  assign pin_gpio_sel = (guard_q == GUARD_GPIO) & ~pin_clear_sel;
  assign brownout_en = ~power_down;
  assign brownout_threshold = rsc_level_thr(level_q);
  assign core_rst_n = core_rst_n_q;
  assign port_preset = por_q;

  // event detection
  wire bo_trip = brownout_en & supply_low & (bo_cnt_q == BW'(BO_FILT_CYC));
  wire ext_assert = pin_clear_sel & ~external_clear_pin;
  wire run = (state_q == RS_RUN);
  wire core_rst_n_d = (state_d == RS_RUN) | (state_d == RS_FAULT_DLY);
  wire guard_bad = ~rsc_guard_ok(guard_q);
  wire level_bad = ~rsc_level_ok(level_q);
  wire fault_done = (state_q == RS_FAULT_DLY) & (cnt_q == '0);
  wire wdt_ctrl_ev = run & watchdog_ctrl_fault;
  wire soft_restore = ~bo_trip & ~ext_assert;
  wire guard_restore = bo_trip | ext_assert | (soft_restore & (fault_done | wdt_ctrl_ev));
  wire level_restore = soft_restore & fault_done & fault_lvl_q;

  // brownout filter
  always_comb begin
    bo_cnt_d = '0;
    if (brownout_en && supply_low) begin
      bo_cnt_d = (bo_cnt_q == BW'(BO_FILT_CYC)) ? bo_cnt_q : bo_cnt_q + 1'b1;
    end
  end

  // reset sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    fault_lvl_d = fault_lvl_q;
    fault_grd_d = fault_grd_q;
    por_d = por_q;
    if (bo_trip) begin
      state_d = RS_HOLD;
      cnt_d = CW'(POR_CYC - 1);
    end else if (ext_assert) begin
      state_d = RS_EXT_LOW;
    end else begin
      unique case (state_q)
        RS_HOLD: begin
          if (cnt_q == '0) begin
            state_d = RS_RUN;
            por_d = 1'b0;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        RS_EXT_LOW: begin
          if (external_clear_pin) begin
            state_d = RS_HOLD;
            cnt_d = CW'(CLR_CYC - 1);
          end
        end
        RS_FAULT_DLY: begin
          if (cnt_q == '0) begin
            state_d = RS_HOLD;
            cnt_d = CW'(CLR_CYC - 1);
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        RS_RUN: begin
          if (watchdog_ctrl_fault || watchdog_timeout) begin
            state_d = RS_HOLD;
            cnt_d = CW'(CLR_CYC - 1);
          end else if (guard_bad || level_bad) begin
            state_d = RS_FAULT_DLY;
            cnt_d = CW'(FAULT_CYC - 1);
            fault_grd_d = guard_bad;
            fault_lvl_d = level_bad;
          end
        end
      endcase
    end
  end

  // registers
  always_comb begin
    guard_d = guard_q;
    level_d = level_q;
    if (wr_guard) guard_d = pwdata[7:0];
    if (guard_restore) guard_d = GUARD_RESET;
    if (wr_level) level_d = pwdata[7:0];
    if (level_restore) level_d = LEVEL_RESET;
    flags_d = flags_q;
    if (wr_flags) flags_d = flags_q & pwdata[FLAGS_W-1:0];
    flags_d[FLG_GUARD] = flags_d[FLG_GUARD] | (soft_restore & fault_done & fault_grd_q);
    flags_d[FLG_LVL] = flags_d[FLG_LVL] | (soft_restore & fault_done & fault_lvl_q);
    flags_d[FLG_BO] = flags_d[FLG_BO] | bo_trip;
    flags_d[FLG_WDT] = flags_d[FLG_WDT] | (soft_restore & wdt_ctrl_ev);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RS_HOLD;
      cnt_q <= CW'(POR_CYC - 1);
      bo_cnt_q <= '0;
      guard_q <= GUARD_RESET;
      level_q <= LEVEL_RESET;
      flags_q <= FLAGS_RESET;
      fault_lvl_q <= 1'b0;
      fault_grd_q <= 1'b0;
      por_q <= 1'b1;
      core_rst_n_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bo_cnt_q <= bo_cnt_d;
      guard_q <= guard_d;
      level_q <= level_d;
      flags_q <= flags_d;
      fault_lvl_q <= fault_lvl_d;
      fault_grd_q <= fault_grd_d;
      por_q <= por_d;
      core_rst_n_q <= core_rst_n_d;
      if (rd_setup) prdata_q <= rd_mux;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  guard_fault_a: assert property (run && guard_bad && !bo_trip && !ext_assert &&
    !watchdog_ctrl_fault && !watchdog_timeout |=> state_q == RS_FAULT_DLY && fault_grd_q)
    else $error("invalid pin code did not start fault delay");

  guard_flag_a: assert property ($fell(flags_q[FLG_GUARD]) |->
    $past(wr_flags) && !$past(pwdata[FLG_GUARD]))
    else $error("guard fault flag cleared without software write");

  bo_flag_a: assert property ($fell(flags_q[FLG_BO]) |->
    $past(wr_flags) && !$past(pwdata[FLG_BO]))
    else $error("brownout flag cleared without software write");

  flag_hi_zero_a: assert property (rd_setup && hit_flags |=> prdata[31:4] == 28'h0000000)
    else $error("cause flag upper bits not zero");

  bo_filter_a: assert property ($rose(flags_q[FLG_BO]) |->
    $past(bo_cnt_q) == BW'(BO_FILT_CYC) && $past(supply_low))
    else $error("brownout reset before filter time");

  bo_pdown_a: assert property (power_down |=> bo_cnt_q == '0 && state_q != RS_HOLD ||
    $past(state_q) != RS_RUN || $past(ext_assert) || $past(watchdog_timeout) ||
    $past(watchdog_ctrl_fault) || $past(guard_bad) || $past(level_bad))
    else $error("brownout acted during power-down");

  bo_level_a: assert property (bo_trip && !wr_level |=> $stable(level_q))
    else $error("brownout reset changed level code");

  ext_release_a: assert property (state_q == RS_EXT_LOW && external_clear_pin &&
    !bo_trip && !ext_assert |=> state_q == RS_HOLD && cnt_q == CW'(CLR_CYC - 1))
    else $error("clear release did not load start-up delay");

  rst_release_a: assert property ($rose(core_rst_n_q) |->
    $past(state_q) == RS_HOLD && $past(cnt_q) == '0)
    else $error("core reset released before delay elapsed");

  guard_restore_a: assert property (ext_assert && !bo_trip |=> guard_q == GUARD_RESET &&
    state_q == RS_EXT_LOW && !core_rst_n_q)
    else $error("clear reset did not restore pin code");

  hold_low_a: assert property (state_q == RS_HOLD |-> !core_rst_n_q)
    else $error("core reset released during hold");

  run_high_a: assert property (state_q == RS_RUN |-> core_rst_n_q)
    else $error("core reset asserted while running");

  fault_run_a: assert property (state_q == RS_FAULT_DLY |-> core_rst_n_q)
    else $error("core reset asserted before fault delay ended");

  ext_low_a: assert property (state_q == RS_EXT_LOW |-> !core_rst_n_q)
    else $error("core reset released while clear pin low");

  preset_hold_a: assert property (por_q |-> !core_rst_n_q)
    else $error("port preset still high after core release");

  preset_end_a: assert property ($fell(por_q) |-> $rose(core_rst_n_q))
    else $error("port preset dropped apart from core release");

  hold_count_a: assert property (state_q == RS_HOLD && cnt_q != '0 &&
    !bo_trip && !ext_assert |=> state_q == RS_HOLD && cnt_q == $past(cnt_q) - 1'b1)
    else $error("start-up delay did not count down");

  bo_trip_a: assert property (bo_trip |=> state_q == RS_HOLD &&
    cnt_q == CW'(POR_CYC - 1) && flags_q[FLG_BO])
    else $error("brownout did not restart the power-on delay");

  bo_count_a: assert property (brownout_en && supply_low &&
    bo_cnt_q != BW'(BO_FILT_CYC) |=> bo_cnt_q == $past(bo_cnt_q) + 1'b1)
    else $error("brownout filter did not count");

  bo_idle_a: assert property (!supply_low |=> bo_cnt_q == '0)
    else $error("brownout filter kept a short dip");

  guard_src_a: assert property ($rose(flags_q[FLG_GUARD]) |->
    $past(fault_done) && $past(fault_grd_q))
    else $error("guard fault flag set without pin code fault");

  guard_set_a: assert property (fault_done && fault_grd_q && !bo_trip && !ext_assert
    |=> flags_q[FLG_GUARD])
    else $error("pin code fault reset did not set its flag");

  level_fault_a: assert property (run && level_bad && !bo_trip && !ext_assert &&
    !watchdog_ctrl_fault && !watchdog_timeout |=> state_q == RS_FAULT_DLY && fault_lvl_q)
    else $error("invalid level code did not start fault delay");

  level_set_a: assert property (fault_done && fault_lvl_q && !bo_trip && !ext_assert
    |=> flags_q[FLG_LVL] && level_q == LEVEL_RESET)
    else $error("level code fault reset did not set flag and restore code");

  level_src_a: assert property ($rose(flags_q[FLG_LVL]) |->
    $past(fault_done) && $past(fault_lvl_q))
    else $error("level fault flag set without level code fault");

  level_clr_a: assert property ($fell(flags_q[FLG_LVL]) |->
    $past(wr_flags) && !$past(pwdata[FLG_LVL]))
    else $error("level fault flag cleared without software write");

  wdt_set_a: assert property (wdt_ctrl_ev && !bo_trip && !ext_assert |=>
    flags_q[FLG_WDT] && state_q == RS_HOLD && guard_q == GUARD_RESET)
    else $error("watchdog control fault reset misbehaved");

  wdt_clr_a: assert property ($fell(flags_q[FLG_WDT]) |->
    $past(wr_flags) && !$past(pwdata[FLG_WDT]))
    else $error("watchdog control flag cleared without software write");

  warm_keep_a: assert property (run && watchdog_timeout && !watchdog_ctrl_fault &&
    !bo_trip && !ext_assert && !wr_guard |=> $stable(guard_q) && state_q == RS_HOLD)
    else $error("warm reset changed pin code");

  fault_end_a: assert property (fault_done && !bo_trip && !ext_assert |=>
    state_q == RS_HOLD && cnt_q == CW'(CLR_CYC - 1) && guard_q == GUARD_RESET)
    else $error("fault delay end did not start reset hold");

  ext_keep_a: assert property (state_q == RS_EXT_LOW && !wr_level |=> $stable(level_q))
    else $error("clear reset changed level code");

  thr_map_a: assert property (level_q == LVL_3V80 |-> brownout_threshold == THR_3V80)
    else $error("top level code not mapped to top threshold");

  level_write_a: assert property (wr_level && !level_restore |=>
    level_q == $past(pwdata[7:0]))
    else $error("level code write lost");
endmodule // rsc_top

// ===== rsc_far_side.sv
`timescale 1ns/1ps
module rsc_far_side (
  input wire logic pclk,
  output logic external_clear_pin,
  output logic supply_low
);
  initial begin
    external_clear_pin = 1'b1; // pull-up keeps pin high when idle
    supply_low = 1'b0;
  end
  task automatic press(input int n);
    external_clear_pin <= 1'b0;
    repeat (n) @(posedge pclk);
    external_clear_pin <= 1'b1;
  endtask
  task automatic dip(input int n);
    supply_low <= 1'b1;
    repeat (n) @(posedge pclk);
    supply_low <= 1'b0;
  endtask
endmodule // rsc_far_side

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import rsc_pkg::*;
  localparam int POR = 20;
  localparam int CLR = 10;
  localparam int FLT = 3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic external_clear_pin, supply_low, power_down, watchdog_timeout, watchdog_ctrl_fault;
  logic core_rst_n, port_preset, pin_clear_sel, pin_gpio_sel, brownout_en;
  rsc_thr_t brownout_threshold;
  int num_errors = 0;
  int checks = 0;
  rsc_far_side FAR (.pclk, .external_clear_pin, .supply_low);
  rsc_top #(.POR_CYC(POR), .CLR_CYC(CLR), .FAULT_CYC(FLT), .BO_FILT_CYC(4)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .external_clear_pin, .supply_low, .power_down, .watchdog_timeout,
    .watchdog_ctrl_fault, .core_rst_n, .port_preset, .pin_clear_sel, .pin_gpio_sel,
    .brownout_en, .brownout_threshold);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic conclude;
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd_q, e);
  endtask
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (core_rst_n !== v && n < 200);
    if (n >= 200) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic bounce;
    int n;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
  endtask
  task automatic t_por;
    int n;
    wait_lvl(1'b1, n);
    chk("por_delay", n, POR + 1);
    chk("port_preset", port_preset, 0);
    rd_chk("guard", ADDR_GUARD, 32'h55);
    rd_chk("level", ADDR_LEVEL, 32'h55);
    rd_chk("flags", ADDR_FLAGS, 32'h0);
    xfer(1'b1, 8'h0C, 32'h1);
    chk("slverr", err_q, 1);
  endtask
  task automatic t_codes;
    logic [7:0] lv [4];
    lv = '{8'h55, 8'h33, 8'h99, 8'hAA};
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, ADDR_LEVEL, {24'h0, lv[i]});
      @(posedge pclk);
      chk("threshold", brownout_threshold, i);
    end
    xfer(1'b1, ADDR_GUARD, 32'hAA);
    @(posedge pclk);
    chk("clear_sel", {pin_gpio_sel, pin_clear_sel}, 1);
    xfer(1'b1, ADDR_GUARD, 32'h55);
    @(posedge pclk);
    chk("gpio_sel", {pin_gpio_sel, pin_clear_sel}, 2);
  endtask
  task automatic t_clear;
    int n;
    xfer(1'b1, ADDR_GUARD, 32'hAA);
    FAR.press(4);
    chk("clear_rst", core_rst_n, 0);
    wait_lvl(1'b1, n);
    chk("clear_delay", n, CLR + 2);
    rd_chk("guard", ADDR_GUARD, 32'h55);
    rd_chk("level", ADDR_LEVEL, 32'hAA);
    rd_chk("flags", ADDR_FLAGS, 32'h0);
  endtask
  task automatic t_brown;
    FAR.dip(4);
    repeat (3) @(posedge pclk);
    chk("short_dip", core_rst_n, 1);
    FAR.dip(8);
    chk("long_dip", core_rst_n, 0);
    rd_chk("bo_flag", ADDR_FLAGS, 32'h4);
    rd_chk("level", ADDR_LEVEL, 32'hAA);
    xfer(1'b1, ADDR_FLAGS, 32'hFF);
    rd_chk("ones_kept", ADDR_FLAGS, 32'h4);
    xfer(1'b1, ADDR_FLAGS, 32'h0);
    rd_chk("cleared", ADDR_FLAGS, 32'h0);
    bounce();
  endtask
  task automatic t_faults;
    int n;
    xfer(1'b1, ADDR_GUARD, 32'h12);
    wait_lvl(1'b0, n);
    chk("fault_delay", n, FLT + 1);
    wait_lvl(1'b1, n);
    rd_chk("guard_flag", ADDR_FLAGS, 32'h8);
    rd_chk("guard", ADDR_GUARD, 32'h55);
    xfer(1'b1, ADDR_FLAGS, 32'h0);
    xfer(1'b1, ADDR_LEVEL, 32'h12);
    bounce();
    rd_chk("lvl_flag", ADDR_FLAGS, 32'h2);
    rd_chk("level", ADDR_LEVEL, 32'h55);
    watchdog_ctrl_fault <= 1'b1;
    @(posedge pclk);
    watchdog_ctrl_fault <= 1'b0;
    bounce();
    rd_chk("wd_flag", ADDR_FLAGS, 32'h3);
    xfer(1'b1, ADDR_GUARD, 32'hAA);
    watchdog_timeout <= 1'b1;
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
    bounce();
    rd_chk("warm_keep", ADDR_GUARD, 32'hAA);
    power_down <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("bo_off", brownout_en, 0);
    FAR.dip(8);
    chk("pd_no_reset", core_rst_n, 1);
    rd_chk("pd_flags", ADDR_FLAGS, 32'h3);
    power_down <= 1'b0;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    power_down = 1'b0;
    watchdog_timeout = 1'b0;
    watchdog_ctrl_fault = 1'b0;
    repeat (20) @(posedge pclk);
    chk("preset_hold", {port_preset, core_rst_n}, 2);
    presetn <= 1'b1;
    t_por();
    t_codes();
    t_clear();
    t_brown();
    t_faults();
    conclude();
  end
endmodule // testbench
